// >>> core/smr_mode_reg_bank.sv
// Mode register bank: write leveling hold, I/O configuration with two set
// points, refresh-rate and thermal status.
// The reserved thermal offset code and the reserved abort value are stored
// as written; keeping them out is left to the host.
// Assumes commands arrive already decoded and synchronous to ref_clk, and
// that the thermal sensor delivers its rate code synchronously as well.
`timescale 1ns/1ps

module smr_mode_reg_bank (
	// Clock and reset
	input  wire logic              ref_clk,
	input  wire logic              rst_n,
	input  wire logic              clkEn,
	// Mode register commands
	input  wire smr_pkg::smr_cmd_s cmd,
	output logic [7:0]             readData,
	output logic                   readValid,
	output logic                   cmdRefused,
	// Set-point selects from the set-point control register
	input  wire logic              writeSetpointSelect,
	input  wire logic              operatingSetpointSelect,
	// Thermal sensor rate code
	input  wire logic [2:0]        sensorRate,
	// Settings the device operates from
	output smr_pkg::smr_opcfg_s    opCfg
);

	smr_pkg::smr_state_s    st;
	smr_pkg::smr_state_s    next_st;
	smr_pkg::smr_sp_field_s spWrData;
	smr_pkg::smr_sp_field_s spRdBack;
	smr_pkg::smr_sp_field_s spActive;
	logic                   accept;
	logic                   ioWrite;

	// Address decode, strobes and readback bytes
	logic                   ioRead;
	logic                   thermRead;
	logic                   hitLatency;
	logic                   hitIoConfig;
	logic                   hitThermal;
	logic                   rateChanged;
	logic [7:0]             ioReadByte;
	logic [7:0]             thermReadByte;

	// Command qualification: leveling admits only writes to the latency register
	always_comb begin
		accept = cmd.valid;
		if (st.state == smr_pkg::SMR_LEVELING) begin
			accept = cmd.valid && cmd.write && hitLatency;
		end
	end

	// Address decode; an unmapped address hits nothing, so its writes fall away
	// and its reads still answer, with zero, to keep the read pipeline regular
	always_comb begin
		hitLatency  = 1'b0;
		hitIoConfig = 1'b0;
		hitThermal  = 1'b0;
		if (cmd.addr == smr_pkg::SMR_LATENCY_MODE_REG_ADDR) begin
			hitLatency = 1'b1;
		end else if (cmd.addr == smr_pkg::SMR_IO_CONFIG_MODE_REG_ADDR) begin
			hitIoConfig = 1'b1;
		end else if (cmd.addr == smr_pkg::SMR_REFRESH_THERMAL_REG_ADDR) begin
			hitThermal = 1'b1;
		end
	end

	// Per-register strobes, all behind the leveling hold; unmapped addresses
	// get no strobe of their own and fall through to the zero answer
	always_comb begin
		ioWrite   = accept && cmd.write && hitIoConfig;
		ioRead    = accept && !cmd.write && hitIoConfig;
		thermRead = accept && !cmd.write && hitThermal;
	end

	// The sensor code is taken as a level; any step away from the last sample
	// counts as a change, even a step back to an earlier code
	assign rateChanged = (sensorRate != st.rateSeen);

	// Duplicated fields taken from the write byte
	// Taken unconditionally; only the store's write strobe decides if they land
	always_comb begin
		spWrData.writeInversionEnable = cmd.data[smr_pkg::SMR_WRINV_BIT];
		spWrData.readInversionEnable  = cmd.data[smr_pkg::SMR_RDINV_BIT];
		spWrData.pulldownDrive        = cmd.data[smr_pkg::SMR_PULLDOWN_DRIVE_LSB +: 3];
		spWrData.writePostambleLength = cmd.data[smr_pkg::SMR_PST_BIT];
	end

	// Set-point store: the access copy follows the write select and the operating
	// copy the operating select, so a retune can be staged ahead of a switch
	smr_setpoint_store smr_setpoint_store_inst (
		.ref_clk                 (ref_clk),
		.rst_n                   (rst_n),
		.clkEn                   (clkEn),
		.wrEn                    (ioWrite),
		.writeSetpointSelect     (writeSetpointSelect),
		.wrData                  (spWrData),
		.rdBack                  (spRdBack),
		.operatingSetpointSelect (operatingSetpointSelect),
		.active                  (spActive)
	);

	// Next state of the bank
	always_comb begin
		// Start from the held state: every field not named below keeps its value
		next_st = st;
		// Pulses last one cycle; a refused command leaves no other trace, so the
		// host learns of it only from the refused pulse
		next_st.readValid = 1'b0;
		next_st.refused   = cmd.valid && !accept;
		// The rate is sampled every live cycle, whether or not anyone reads it
		next_st.rateSeen  = sensorRate;

		// A read clears the flag first so that a change in the same cycle wins
		if (thermRead) begin
			next_st.tempUpdateFlag = 1'b0;
		end
		if (rateChanged) begin
			next_st.tempUpdateFlag = 1'b1;
		end

		if (accept && cmd.write) begin
			if (cmd.addr == smr_pkg::SMR_LATENCY_MODE_REG_ADDR) begin
				// Other latency fields live elsewhere; only the leveling bit matters
				if (cmd.data[smr_pkg::SMR_WRLEV_BIT]) begin
					next_st.state = smr_pkg::SMR_LEVELING;
				end else begin
					next_st.state = smr_pkg::SMR_NORMAL;
				end
			end else if (cmd.addr == smr_pkg::SMR_IO_CONFIG_MODE_REG_ADDR) begin
				// Pull-up point is a single copy for both set points; the host keeps
				// it matched across channels before a calibration start
				next_st.pullupCalPoint = cmd.data[smr_pkg::SMR_PUCAL_BIT];
				// Sticky: a write may set protection but never clear it
				if (cmd.data[smr_pkg::SMR_PROT_BIT]) begin
					next_st.repairProtection = 1'b1;
				end
			end else if (cmd.addr == smr_pkg::SMR_REFRESH_THERMAL_REG_ADDR) begin
				// Rate and flag bits of the write byte are dropped
				// The abort bit is kept as written; its reserved value is not trapped
				next_st.selfRefreshAbort = cmd.data[smr_pkg::SMR_ABORT_BIT];
				next_st.thermalOffset    = smr_pkg::smr_offset_e'(
					cmd.data[smr_pkg::SMR_OFFSET_LSB +: 2]);
				if (!cmd.data[smr_pkg::SMR_ENTRY_BIT]) begin
					next_st.repairEntry = 1'b0;
				end else if (!st.repairProtection) begin
					next_st.repairEntry = 1'b1;
				end
			end
		end

		// Read answer one cycle after the command; unmapped addresses answer zero
		if (accept && !cmd.write) begin
			next_st.readValid = 1'b1;
			if (ioRead) begin
				next_st.readData = ioReadByte;
			end else if (thermRead) begin
				next_st.readData = thermReadByte;
			end else begin
				next_st.readData = 8'h00;
			end
		end
	end

	// I/O configuration readback from the write-selected copy; pull-up point
	// and protection are single copies, so both set points show one value there
	always_comb begin
		ioReadByte                             = 8'h00;
		ioReadByte[smr_pkg::SMR_WRINV_BIT]     = spRdBack.writeInversionEnable;
		ioReadByte[smr_pkg::SMR_RDINV_BIT]     = spRdBack.readInversionEnable;
		ioReadByte[smr_pkg::SMR_PULLDOWN_DRIVE_LSB +: 3] = spRdBack.pulldownDrive;
		ioReadByte[smr_pkg::SMR_PROT_BIT]      = st.repairProtection;
		ioReadByte[smr_pkg::SMR_PST_BIT]       = spRdBack.writePostambleLength;
		ioReadByte[smr_pkg::SMR_PUCAL_BIT]     = st.pullupCalPoint;
	end

	// Thermal readback; offset, entry and abort are write-only and read as
	// zero, so a host cannot mistake its own last write for live status
	always_comb begin
		thermReadByte                             = 8'h00;
		thermReadByte[smr_pkg::SMR_RATE_LSB +: 3] = st.rateSeen;
		thermReadByte[smr_pkg::SMR_TUF_BIT]       = st.tempUpdateFlag;
	end

	// Synchronous reset doubles as power-on reset, the only way out of protection
	// Clock enable does not gate reset, and both copies in the store clear with it
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st.state            <= smr_pkg::SMR_NORMAL;
			st.pullupCalPoint   <= smr_pkg::SMR_PUCAL_RESET;
			st.repairProtection <= 1'b0;
			st.repairEntry      <= 1'b0;
			st.selfRefreshAbort <= 1'b0;
			st.thermalOffset    <= smr_pkg::SMR_OFFSET_NONE;
			st.rateSeen         <= smr_pkg::SMR_RATE_RESET;
			st.tempUpdateFlag   <= 1'b0;
			st.readData         <= 8'h00;
			st.readValid        <= 1'b0;
			st.refused          <= 1'b0;
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	// Outputs; the long postamble is only meant for fast clocks, not checked here
	// The read byte holds its last answer until the next taken read
	assign readData   = st.readData;
	assign readValid  = st.readValid;
	assign cmdRefused = st.refused;

	// Settings; the active copy is a mux on the operating select, so a set-point
	// switch takes effect at once, with no extra register stage
	always_comb begin
		opCfg.active           = spActive;
		opCfg.pullupCalPoint   = st.pullupCalPoint;
		opCfg.repairProtection = st.repairProtection;
		opCfg.repairEntry      = st.repairEntry;
		opCfg.selfRefreshAbort = st.selfRefreshAbort;
		opCfg.thermalOffset    = st.thermalOffset;
		opCfg.writeLeveling    = (st.state == smr_pkg::SMR_LEVELING);
	end

endmodule

// >>> core/smr_pkg.sv
// Shared types and constants for the mode register bank of a mobile SDRAM.
// Assumes one clock domain; the command decoder outside hands over whole
// mode register write and read commands, one per cycle at most.
package smr_pkg;

	// Mode register addresses
	localparam logic [5:0] SMR_LATENCY_MODE_REG_ADDR  = 6'h02;
	localparam logic [5:0] SMR_IO_CONFIG_MODE_REG_ADDR = 6'h03;
	localparam logic [5:0] SMR_REFRESH_THERMAL_REG_ADDR = 6'h04;

	// Field positions in the latency register
	localparam int SMR_WRLEV_BIT = 7;

	// Field positions in the I/O configuration register
	localparam int SMR_PUCAL_BIT  = 0;
	localparam int SMR_PST_BIT    = 1;
	localparam int SMR_PROT_BIT   = 2;
	localparam int SMR_PULLDOWN_DRIVE_LSB   = 3;
	localparam int SMR_RDINV_BIT  = 6;
	localparam int SMR_WRINV_BIT  = 7;

	// Field positions in the refresh/thermal register
	localparam int SMR_RATE_LSB   = 0;
	localparam int SMR_ABORT_BIT  = 3;
	localparam int SMR_ENTRY_BIT  = 4;
	localparam int SMR_OFFSET_LSB = 5;
	localparam int SMR_TUF_BIT    = 7;

	// Values after reset
	localparam logic       SMR_PUCAL_RESET = 1'b1;
	localparam logic [2:0] SMR_PULLDOWN_DRIVE_RESET  = 3'h6;
	localparam logic [2:0] SMR_RATE_RESET  = 3'h3;
	localparam logic [1:0] SMR_OFFSET_RESET = 2'h0;

	// Refresh rate codes
	typedef enum logic [2:0] {
		SMR_RATE_LOW_LIMIT = 3'b000,
		SMR_RATE_4X        = 3'b001,
		SMR_RATE_2X        = 3'b010,
		SMR_RATE_1X        = 3'b011,
		SMR_RATE_HALF      = 3'b100,
		SMR_RATE_QUARTER   = 3'b101,
		SMR_RATE_QTR_DERATE = 3'b110,
		SMR_RATE_HIGH_LIMIT = 3'b111
	} smr_rate_e;

	// Thermal offset codes
	typedef enum logic [1:0] {
		SMR_OFFSET_NONE = 2'b00,
		SMR_OFFSET_5C   = 2'b01,
		SMR_OFFSET_10C  = 2'b10,
		SMR_OFFSET_RSVD = 2'b11
	} smr_offset_e;

	// Bank state: normal or held by write leveling
	typedef enum logic [0:0] {
		SMR_NORMAL   = 1'b0,
		SMR_LEVELING = 1'b1
	} smr_state_e;

	// One command from the command bus
	typedef struct packed {
		logic       valid;
		logic       write;
		logic [5:0] addr;
		logic [7:0] data;
	} smr_cmd_s;

	// Fields held once per set point
	typedef struct packed {
		logic       writeInversionEnable;
		logic       readInversionEnable;
		logic [2:0] pulldownDrive;
		logic       writePostambleLength;
	} smr_sp_field_s;

	localparam smr_sp_field_s SMR_SP_RESET = '{1'b0, 1'b0, SMR_PULLDOWN_DRIVE_RESET, 1'b0};

	// State of the set-point store
	typedef struct packed {
		smr_sp_field_s [1:0] copy;
	} smr_sp_state_s;

	// Settings the device operates from
	typedef struct packed {
		smr_sp_field_s active;
		logic          pullupCalPoint;
		logic          repairProtection;
		logic          repairEntry;
		logic          selfRefreshAbort;
		smr_offset_e   thermalOffset;
		logic          writeLeveling;
	} smr_opcfg_s;

	// State of the main bank
	typedef struct packed {
		smr_state_e  state;
		logic        pullupCalPoint;
		logic        repairProtection;
		logic        repairEntry;
		logic        selfRefreshAbort;
		smr_offset_e thermalOffset;
		logic [2:0]  rateSeen;
		logic        tempUpdateFlag;
		logic [7:0]  readData;
		logic        readValid;
		logic        refused;
	} smr_state_s;

endpackage

// >>> core/smr_setpoint_store.sv
// Two physical copies of the set-point duplicated fields.
// Assumes the write strobe is already decoded for the I/O configuration address.
`timescale 1ns/1ps

module smr_setpoint_store (
	// Clock and reset
	input  wire logic                   ref_clk,
	input  wire logic                   rst_n,
	input  wire logic                   clkEn,
	// Access side, steered by the write set-point select
	input  wire logic                   wrEn,
	input  wire logic                   writeSetpointSelect,
	input  wire smr_pkg::smr_sp_field_s wrData,
	output smr_pkg::smr_sp_field_s      rdBack,
	// Operating side, steered by the operating set-point select
	input  wire logic                   operatingSetpointSelect,
	output smr_pkg::smr_sp_field_s      active
);

	smr_pkg::smr_sp_state_s st;
	smr_pkg::smr_sp_state_s next_st;

	// Only the copy named by the write select takes the write
	always_comb begin
		next_st = st;
		for (int i = 0; i < 2; i++) begin
			if (wrEn && (writeSetpointSelect == i[0])) begin
				next_st.copy[i] = wrData;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			st <= '{copy: '{smr_pkg::SMR_SP_RESET, smr_pkg::SMR_SP_RESET}};
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	// Reads see the access copy; the device acts on the operating copy only,
	// so writing the other copy cannot disturb a running interface
	assign rdBack = st.copy[writeSetpointSelect];
	assign active = st.copy[operatingSetpointSelect];

endmodule

// >>> sim/smr_mode_reg_bank_checker.sv
// Port checks for the mode register bank.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps

module smr_mode_reg_bank_checker (
	// Clock and reset
	input wire logic                ref_clk,
	input wire logic                rst_n,
	input wire logic                clkEn,
	// Commands and answers
	input wire smr_pkg::smr_cmd_s   cmd,
	input wire logic [7:0]          readData,
	input wire logic                readValid,
	input wire logic                cmdRefused,
	// Selects, sensor, settings
	input wire logic                writeSetpointSelect,
	input wire logic                operatingSetpointSelect,
	input wire logic [2:0]          sensorRate,
	input wire smr_pkg::smr_opcfg_s opCfg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// Taken commands; leveling turns away all but writes to the latency register
	logic acc;
	logic lvExit;
	logic ok;
	assign acc = clkEn && cmd.valid && !opCfg.writeLeveling;
	assign lvExit = clkEn && cmd.valid && cmd.write && cmd.addr == 6'h02;
	assign ok = rst_n && clkEn;
	sequence s_wr03; acc && cmd.write && cmd.addr == 6'h03; endsequence
	sequence s_wr04; acc && cmd.write && cmd.addr == 6'h04; endsequence
	// Two live cycles before the read, else the rate sample is still the reset value
	sequence s_rd04; acc && !cmd.write && cmd.addr == 6'h04 && $past(ok) && $past(ok, 2); endsequence

	a_level_hold:
		assert property (opCfg.writeLeveling && !lvExit |=> opCfg.writeLeveling) else $error("leveling left");
	a_level_refuse:
		assert property (opCfg.writeLeveling && clkEn && cmd.valid && !lvExit |=> cmdRefused && !readValid)
			else $error("command not refused");
	a_prot_sticky:
		assert property (opCfg.repairProtection |=> opCfg.repairProtection) else $error("protection cleared");
	a_entry_block:
		assert property ((opCfg.repairProtection && cmd.data[4] ##0 s_wr04) |=> $stable(opCfg.repairEntry))
			else $error("repair entry not blocked");
	a_offset_write:
		assert property (s_wr04 |=> opCfg.thermalOffset == $past(cmd.data[6:5])) else $error("offset wrong");
	a_rate_read:
		assert property (s_rd04 |=> readValid && readData[6:0] == {4'h0, $past(sensorRate, 2)})
			else $error("rate read wrong");
	a_flag_set:
		assert property ((s_rd04 ##0 $past(sensorRate) != $past(sensorRate, 2)) |=> readData[7])
			else $error("update flag missing");
	a_copy_write:
		assert property ((writeSetpointSelect == operatingSetpointSelect ##0 s_wr03) |=>
			$changed(operatingSetpointSelect) || opCfg.active == {$past(cmd.data[7:3]), $past(cmd.data[1])})
			else $error("active copy not written");
	a_inactive_copy:
		assert property ((writeSetpointSelect != operatingSetpointSelect ##0 s_wr03) |=>
			$changed(operatingSetpointSelect) || $stable(opCfg.active)) else $error("inactive copy leaked");
endmodule

bind smr_mode_reg_bank smr_mode_reg_bank_checker smr_mode_reg_bank_checker_inst (
	.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn), .cmd(cmd), .readData(readData),
	.readValid(readValid), .cmdRefused(cmdRefused), .writeSetpointSelect(writeSetpointSelect),
	.operatingSetpointSelect(operatingSetpointSelect), .sensorRate(sensorRate), .opCfg(opCfg));

// >>> sim/smr_host_model.sv
// Host controller model issuing one mode register command per call, none in leveling except latency writes or rogue ones.
// Assumes answers are registered on the taking edge, one cycle after the command is driven.
`timescale 1ns/1ps

module smr_host_model (
	// Clock and bank status
	input  wire logic                ref_clk,
	input  wire smr_pkg::smr_opcfg_s opCfg,
	input  wire logic [7:0]          readData,
	input  wire logic                readValid,
	input  wire logic                cmdRefused,
	// Lets a scenario break the leveling order on purpose
	input  wire logic                rogue,
	// Command bus
	output smr_pkg::smr_cmd_s        cmd
);
	initial cmd = '0;

	// One-cycle command; idle fields show the inverse so stale values never pass
	task automatic send(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] rd, output logic rv, output logic rf);
		@(posedge ref_clk);
		if (!opCfg.writeLeveling || (w && a == 6'h02) || rogue) begin
			cmd <= '{1'b1, w, a, (w && a == 6'h04) ? d & 8'hf7 : d};
			@(posedge ref_clk);
			cmd <= '{1'b0, ~w, ~a, ~d};
		end
		#1;
		rd = readData;
		rv = readValid;
		rf = cmdRefused;
	endtask
endmodule

// >>> sim/smr_mode_reg_bank_tb_top.sv
// Self-checking bench for the mode register bank.
// Assumes the host model drives the command bus.
`timescale 1ns/1ps

module smr_mode_reg_bank_tb_top;
	typedef struct packed {logic [5:0] a; logic [7:0] d; logic [7:0] e;} smr_row_s;
	logic                ref_clk = 1'b0;
	logic                rst_n = 1'b0;
	logic                wSel = 1'b0;
	logic                oSel = 1'b0;
	logic                rogue = 1'b0;
	logic                clkEn = 1'b1;
	logic [2:0]          sensorRate = 3'h3;
	smr_pkg::smr_cmd_s   cmd;
	smr_pkg::smr_opcfg_s opCfg;
	logic [7:0]          readData;
	logic [7:0]          rd;
	logic                readValid;
	logic                cmdRefused;
	logic                rv;
	logic                rf;
	int                  fail_count = 0;
	int                  tests_run = 0;
	// Address, data, expected readback or thermal fields
	smr_row_s rows [7] = '{'{6'h04, 8'h30, 8'h30}, '{6'h04, 8'h47, 8'h40}, '{6'h04, 8'h60, 8'h60},
		'{6'h03, 8'hc9, 8'hc9}, '{6'h03, 8'h36, 8'h36}, '{6'h03, 8'h00, 8'h04},
		'{6'h04, 8'h10, 8'h00}};

	always #2.5 ref_clk = ~ref_clk;

	smr_mode_reg_bank smr_mode_reg_bank_inst (.ref_clk(ref_clk), .rst_n(rst_n), .clkEn(clkEn),
		.cmd(cmd), .readData(readData), .readValid(readValid), .cmdRefused(cmdRefused),
		.writeSetpointSelect(wSel), .operatingSetpointSelect(oSel), .sensorRate(sensorRate),
		.opCfg(opCfg));
	smr_host_model smr_host_model_inst (.ref_clk(ref_clk), .opCfg(opCfg), .readData(readData),
		.readValid(readValid), .cmdRefused(cmdRefused), .rogue(rogue), .cmd(cmd));

	// Byte compare, bits are zero-extended by callers
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		smr_host_model_inst.send(1'b1, a, d, rd, rv, rf);
	endtask
	task automatic rdChk(input logic [5:0] a, input logic [7:0] e);
		smr_host_model_inst.send(1'b0, a, 8'h00, rd, rv, rf);
		chk("readValid", 8'h01, {7'h0, rv});
		chk("readData", e, rd);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	// Reset, set points, table rows, leveling, thermal flag, second reset
	initial begin
		repeat (2) @(posedge ref_clk);
		rst_n <= 1'b1;
		rdChk(6'h03, 8'h31);
		rdChk(6'h04, 8'h03);
		@(posedge ref_clk) wSel <= 1'b1;
		wr(6'h03, 8'hca);
		chk("active", 8'h0c, {2'h0, opCfg.active});
		chk("pullup", 8'h00, {7'h0, opCfg.pullupCalPoint});
		rdChk(6'h03, 8'hca);
		@(posedge ref_clk) oSel <= 1'b1;
		#1 chk("active", 8'h33, {2'h0, opCfg.active});
		@(posedge ref_clk) wSel <= 1'b0;
		rdChk(6'h03, 8'h30);
		@(posedge ref_clk) oSel <= 1'b0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			if (rows[i].a == 6'h03) rdChk(6'h03, rows[i].e);
			else chk("thermal", rows[i].e, {1'b0, opCfg.thermalOffset, opCfg.repairEntry,
				opCfg.selfRefreshAbort, 3'h0});
		end
		@(posedge ref_clk) clkEn <= 1'b0;
		wr(6'h04, 8'h20);
		chk("frozen", 8'h00, {6'h0, opCfg.thermalOffset});
		@(posedge ref_clk) clkEn <= 1'b1;
		wr(6'h02, 8'h80);
		rogue = 1'b1;
		smr_host_model_inst.send(1'b0, 6'h04, 8'h00, rd, rv, rf);
		chk("refused", 8'h01, {7'h0, rf & opCfg.writeLeveling});
		rogue = 1'b0;
		wr(6'h02, 8'h00);
		chk("leveling", 8'h00, {7'h0, opCfg.writeLeveling});
		for (int r = 0; r < 8; r++) begin
			@(posedge ref_clk) sensorRate <= 3'(r);
			rdChk(6'h04, {1'b1, 4'h0, 3'(r)});
		end
		rdChk(6'h04, 8'h07);
		@(posedge ref_clk) rst_n <= 1'b0;
		@(posedge ref_clk) rst_n <= 1'b1;
		rdChk(6'h03, 8'h31);
		end_sim();
	end
endmodule
